// File: design/eif_pkg.sv
package eif_pkg;
  // ------------------------------------------------------------
  // channels and register map
  // ------------------------------------------------------------
  localparam int unsigned NUM_CH        = 6;
  localparam logic [7:0]  ADDR_GATE     = 8'h00;
  localparam logic [7:0]  ADDR_CTRL1    = 8'h04;
  localparam logic [7:0]  ADDR_CTRL4    = 8'h10;
  localparam logic [7:0]  ADDR_MODE     = 8'h14;
  localparam logic [7:0]  ADDR_ENABLE   = 8'h18;
  localparam logic [7:0]  ADDR_PEND     = 8'h1C;
  localparam logic [7:0]  ADDR_PINDIR   = 8'h20;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
  // control register field positions
  localparam int unsigned NC_LSB        = 0;
  localparam int unsigned ES_LSB        = 2;
  localparam int unsigned LVL_BIT       = 4;
  // ------------------------------------------------------------
  // edge select and sampling interval encodings
  // ------------------------------------------------------------
  localparam logic [1:0]  ES_RISE       = 2'h0;
  localparam logic [1:0]  ES_FALL       = 2'h1;
  localparam logic [1:0]  ES_BOTH       = 2'h2;
  localparam logic [1:0]  ES_HIGH       = 2'h3;
  localparam logic [1:0]  NC_DIV1       = 2'h0;
  localparam logic [1:0]  NC_DIV4       = 2'h1;
  localparam logic [1:0]  NC_DIV8       = 2'h2;
  localparam logic [1:0]  NC_DIV16      = 2'h3;
  localparam int unsigned FAST_SAMPLES  = 3;
  localparam int unsigned SLOW_SAMPLES  = 2;
  localparam int unsigned SLOW_DIV      = 4;
  localparam int unsigned FIXED_SLOW_SAMPLES = 3;
  localparam int unsigned CNT_W         = 4;
  // ------------------------------------------------------------
  // operating modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_FAST_RUN  = 3'b000,
    MODE_FAST_HALT = 3'b001,
    MODE_LOW_RUN   = 3'b010,
    MODE_LOW_HALT  = 3'b011,
    MODE_DEEP_FAST = 3'b100,
    MODE_DEEP_LOW  = 3'b101,
    MODE_STOP      = 3'b110
  } eif_mode_e;
  typedef struct packed {
    logic [1:0] edge_sel;
    logic [1:0] interval;
  } eif_cfg_s;
  typedef struct packed {
    logic       fast;
    logic       slow;
    logic       slow_tick;
  } eif_timing_s;
endpackage

// File: design/eif_filter.sv
`timescale 1ns/1ns
// per-channel noise filter and request detector
module eif_filter #(
  parameter bit SELECTABLE = 1'b1,
  parameter bit HIGH_LEVEL = 1'b0
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 run,
  input  wire eif_pkg::eif_timing_s timing,
  input  wire eif_pkg::eif_cfg_s    cfg,
  input  wire logic                 pin,
  output logic                      req,
  output logic                      level
);
  typedef struct packed {
    logic                      sync;
    logic [eif_pkg::CNT_W-1:0] div;
    logic [2:0]                hist;
    logic                      filt;
    logic                      req;
  } eif_flt_s;
  eif_flt_s s_q;
  eif_flt_s s_d;
  logic     tick;
  logic     nxt;
  logic     rise;
  logic     fall;
  always_comb begin
    s_d  = s_q;
    tick = 1'b0;
    nxt  = s_q.filt;
    s_d.req = 1'b0;
    s_d.sync = pin;
    if (timing.fast) begin
      if (!SELECTABLE) begin
        tick = 1'b1;
      end else begin
        s_d.div = s_q.div + 4'h1;
        case (cfg.interval)
          eif_pkg::NC_DIV1:  tick = 1'b1;
          eif_pkg::NC_DIV4:  tick = (s_q.div[1:0] == 2'h3);
          eif_pkg::NC_DIV8:  tick = (s_q.div[2:0] == 3'h7);
          default:           tick = (s_q.div == 4'hF);
        endcase
      end
    end else if (timing.slow) begin
      tick = timing.slow_tick;
    end
    if (run && tick) begin
      s_d.hist = {s_q.hist[1:0], s_q.sync};
      if (!SELECTABLE && timing.fast) begin
        nxt = (s_q.sync == s_d.hist[1]) ? s_q.sync : s_q.filt;
      end else if (timing.fast) begin
        if (s_d.hist == 3'h7) nxt = 1'b1;
        else if (s_d.hist == 3'h0) nxt = 1'b0;
      end else begin
        if (s_d.hist[1:0] == 2'h3) nxt = 1'b1;
        else if (s_d.hist[1:0] == 2'h0) nxt = 1'b0;
      end
    end
    if (!run) begin
      s_d.div = '0;
    end
    s_d.filt = nxt;
    rise = nxt & ~s_q.filt;
    fall = ~nxt & s_q.filt;
    if (!SELECTABLE) begin
      s_d.req = fall;
    end else begin
      case (cfg.edge_sel)
        eif_pkg::ES_RISE: s_d.req = rise;
        eif_pkg::ES_FALL: s_d.req = fall;
        eif_pkg::ES_BOTH: s_d.req = rise | fall;
        default:          s_d.req = HIGH_LEVEL & run & nxt;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign req   = s_q.req;
  assign level = s_q.filt;
endmodule

// File: design/eif_top.sv
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Overview of operation
// - channels one to four configurable; zero and five fixed
// - channel zero requests on falling edge only
// - fixed filter: under one gear clock rejected, two accepted
// - slow modes: under four low clocks rejected, eight accepted
// - edge code 00 rise, 01 fall, 10 both, 11 reserved
// - channel four code 11 requests while filtered input high
// - filtered level captured into level flag on each request
// - level flag updated per request, held between
// - level flag reads 0 initially or after low, 1 after high
// - fast modes: three equal samples at interval accept level on channels one to four
// - interval 00 every clock, 01 /4, 10 /8, 11 /16
// - under two intervals rejected, over three plus one accepted
// - slow modes sample at low clock /4, two equal samples
// - deep halt and stop modes halt sampling and detection
// - clock gate bit 0 stops logic, 1 restores
// - reset clears clock gate bit
// - pin in output mode reads low, may raise request
// ----------------------------------------------------------------
module eif_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  ext_irq_pins,
  input  wire logic        low_freq_clock,
  input  wire logic        master_irq_enable,
  output logic      [5:0]  irq_accept
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                        wr_pend;
    logic                        rd_pend;
    logic [7:0]                  addr;
    logic [31:0]                 rdata;
    logic                        clock_gate_enable;
    eif_pkg::eif_mode_e          mode;
    eif_pkg::eif_cfg_s [3:0]     cfg;
    logic [5:0]                  source_enable_bit;
    logic [5:0]                  captured_level_flag;
    logic [5:0]                  pend;
    logic [5:0]                  pin_out;
    logic [5:0]                  accept;
    logic [1:0]                  lf_div;
    logic                        lf_sync1;
    logic                        lf_sync2;
    logic                        lf_prev;
    logic                        slow_tick;
  } eif_top_s;
  eif_top_s s_q;
  eif_top_s s_d;
  logic [5:0] req;
  logic [5:0] level;
  logic [5:0] pin_in;
  logic       run;
  logic       fast;
  logic       slow;
  logic       take;
  eif_pkg::eif_timing_s timing;
  assign fast = (s_q.mode == eif_pkg::MODE_FAST_RUN) || (s_q.mode == eif_pkg::MODE_FAST_HALT);
  assign slow = (s_q.mode == eif_pkg::MODE_LOW_RUN) || (s_q.mode == eif_pkg::MODE_LOW_HALT);
  assign run  = s_q.clock_gate_enable & (fast | slow);
  assign timing = '{fast: fast, slow: slow, slow_tick: s_q.slow_tick};
  assign pin_in = ext_irq_pins & ~s_q.pin_out;
  assign take = hsel & hready & htrans[1];
  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < eif_pkg::NUM_CH; g++) begin : g_ch
      eif_pkg::eif_cfg_s c;
      if (g >= 1 && g <= 4) begin : g_sel
        assign c = s_q.cfg[g-1];
      end else begin : g_fix
        assign c = '{edge_sel: eif_pkg::ES_FALL, interval: eif_pkg::NC_DIV1};
      end
      eif_filter #(
        .SELECTABLE (g >= 1 && g <= 4),
        .HIGH_LEVEL (g == 4)
      ) u_flt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .run     (run),
        .timing  (timing),
        .cfg     (c),
        .pin     (pin_in[g]),
        .req     (req[g]),
        .level   (level[g])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.wr_pend = 1'b0;
    s_d.rd_pend = 1'b0;
    // low clock is sampled, divided by four to the slow sample tick
    s_d.lf_sync1 = low_freq_clock;
    s_d.lf_sync2 = s_q.lf_sync1;
    s_d.lf_prev  = s_q.lf_sync2;
    s_d.slow_tick = 1'b0;
    if (s_q.lf_sync2 & ~s_q.lf_prev) begin
      s_d.lf_div = s_q.lf_div + 2'h1;
      s_d.slow_tick = (s_q.lf_div == 2'h3);
    end
    for (int i = 0; i < eif_pkg::NUM_CH; i++) begin
      if (req[i]) begin
        s_d.captured_level_flag[i] = level[i];
      end
    end
    s_d.accept = '0;
    for (int i = 0; i < eif_pkg::NUM_CH; i++) begin
      s_d.accept[i] = s_q.pend[i] & master_irq_enable & s_q.source_enable_bit[i];
    end
    // the latch clears on a software write or on its own accept; a new request wins over both
    if (s_q.wr_pend && s_q.addr == eif_pkg::ADDR_PEND) begin
      s_d.pend = s_q.pend & ~hwdata[5:0];
    end
    s_d.pend = (s_d.pend & ~s_d.accept) | req;
    if (s_q.wr_pend) begin
      if (s_q.addr == eif_pkg::ADDR_GATE) begin
        s_d.clock_gate_enable = hwdata[0];
      end else if (s_q.addr == eif_pkg::ADDR_MODE) begin
        s_d.mode = eif_pkg::eif_mode_e'(hwdata[2:0]);
      end else if (s_q.addr == eif_pkg::ADDR_ENABLE) begin
        s_d.source_enable_bit = hwdata[5:0];
      end else if (s_q.addr == eif_pkg::ADDR_PINDIR) begin
        s_d.pin_out = hwdata[5:0];
      end else if (s_q.addr >= eif_pkg::ADDR_CTRL1 && s_q.addr <= eif_pkg::ADDR_CTRL4) begin
        s_d.cfg[s_q.addr[4:2] - 3'h1] = hwdata[3:0];
      end
    end
    s_d.rdata = eif_pkg::RESET_WORD;
    if (take) begin
      s_d.addr    = haddr[7:0];
      s_d.wr_pend = hwrite;
      s_d.rd_pend = ~hwrite;
      if (haddr[7:0] == eif_pkg::ADDR_GATE) begin
        s_d.rdata[0] = s_q.clock_gate_enable;
      end else if (haddr[7:0] == eif_pkg::ADDR_MODE) begin
        s_d.rdata[2:0] = s_q.mode;
      end else if (haddr[7:0] == eif_pkg::ADDR_ENABLE) begin
        s_d.rdata[5:0] = s_q.source_enable_bit;
      end else if (haddr[7:0] == eif_pkg::ADDR_PEND) begin
        s_d.rdata[5:0] = s_q.pend;
      end else if (haddr[7:0] == eif_pkg::ADDR_PINDIR) begin
        s_d.rdata[5:0] = s_q.pin_out;
      end else if (haddr[7:0] >= eif_pkg::ADDR_CTRL1 && haddr[7:0] <= eif_pkg::ADDR_CTRL4) begin
        s_d.rdata[3:0] = s_q.cfg[haddr[4:2] - 3'h1];
        s_d.rdata[eif_pkg::LVL_BIT] = s_q.captured_level_flag[haddr[4:2]];
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign hrdata     = s_q.rdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign irq_accept = s_q.accept;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_gate_reset: assert property (@(posedge ref_clk) rst |=> !s_q.clock_gate_enable)
    else $error("gate not cleared by reset");
  a_accept_gated: assert property (@(posedge ref_clk) disable iff (rst)
    |irq_accept |-> $past(master_irq_enable))
    else $error("accept without master enable");
  a_no_req_stopped: assert property (@(posedge ref_clk) disable iff (rst)
    (!run)[*2] |-> req == 6'h00)
    else $error("request while stopped");
  a_level_capture: assert property (@(posedge ref_clk) disable iff (rst)
    req[1] |=> s_q.captured_level_flag[1] == $past(level[1]))
    else $error("level not captured");
  a_level_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !req[2] |=> $stable(s_q.captured_level_flag[2]))
    else $error("level changed without request");
  a_ch0_fall: assert property (@(posedge ref_clk) disable iff (rst)
    req[0] |-> !level[0])
    else $error("channel zero rose");
  // gate off must silence the filters themselves, not just the run term
  a_gate_off: assert property (@(posedge ref_clk) disable iff (rst)
    (!s_q.clock_gate_enable)[*2] |-> req == 6'h00)
    else $error("request with gate off");
  // fixed filter needs two equal samples after the synchroniser stage
  a_out_low: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.pin_out[0] && run && fast)[*3] |=> !level[0])
    else $error("output pin not forced low");
endmodule

// File: tb/eif_src.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// external pin sources: idle high, one low pulse per command of nonzero length
// ------------------------------------------------------------
module eif_src (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [2:0] ch,
  input  wire logic [7:0] len,
  output logic      [5:0] pins
);
  int         left;
  logic [2:0] sel;
  initial begin
    pins = 6'h3F;
    left = 0;
    sel  = 3'h0;
  end
  // pulses stay far apart so noise never runs back to back
  always @(posedge ref_clk) begin
    if (go && len != 8'h00) begin
      pins[ch] <= 1'b0;
      left     <= len;
      sel      <= ch;
    end else if (left > 1) begin
      left <= left - 1;
    end else if (left == 1) begin
      pins[sel] <= 1'b1;
      left      <= 0;
    end
  end
endmodule

// File: tb/ext_irq_edge_noise_filter_tb.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module ext_irq_edge_noise_filter_tb;
  logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, lfc, master, go;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ch;
  logic [7:0]  len, lfsr;
  logic [5:0]  pins, acc;
  int          fails, n_checks, cyc, div;
  int          cnt[6];
  eif_top eif_top_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_irq_pins(pins), .low_freq_clock(lfc), .master_irq_enable(master),
    .irq_accept(acc));
  eif_src eif_src_i (.ref_clk(ref_clk), .go(go), .ch(ch), .len(len), .pins(pins));
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic conclude();
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  // configure with sources masked, settle, clear latch, pulse, count accepts
  task automatic scen(input logic [7:0] a, input logic [31:0] d, input logic [2:0] c,
                      input logic [7:0] w, input logic [31:0] e);
    wr(eif_pkg::ADDR_ENABLE, 32'h0000_0000);
    wr(a, d);
    repeat (120) @(posedge ref_clk);
    wr(eif_pkg::ADDR_PEND, 32'h0000_003F);
    wr(eif_pkg::ADDR_ENABLE, 32'h0000_003F);
    foreach (cnt[i]) cnt[i] = 0;
    ch  <= c;
    len <= w;
    go  <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (250) @(posedge ref_clk);
    check((cnt[c] > 3) ? 32'h3 : 32'(cnt[c]), e);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // low clock of 8 gear clocks; watchdog on the whole run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    lfc <= cyc[2];
    for (int i = 0; i < 6; i++) if (acc[i] === 1'b1) cnt[i]++;
    if (cyc == 40000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; master = 1'b1; go = 1'b0; ch = 3'h0;
    len = 8'h00; lfc = 1'b0; lfsr = 8'h3E; fails = 0; n_checks = 0; cyc = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, eif_pkg::ADDR_GATE, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    bus(1'b0, eif_pkg::ADDR_CTRL1, 32'h0, rd);
    check(rd, 32'h0);
    wr(eif_pkg::ADDR_GATE, 32'h1);
    for (int c = 0; c < 6; c += 5) begin
      scen(eif_pkg::ADDR_MODE, 32'h0, 3'(c), 8'h01, 32'h0);
      scen(eif_pkg::ADDR_MODE, 32'h0, 3'(c), 8'h02, 32'h1);
    end
    for (int es = 0; es < 4; es++) begin
      scen(eif_pkg::ADDR_CTRL1, 32'(es << 2), 3'h1, 8'h1E, 32'(es == 2 ? 2 : es < 2));
      bus(1'b0, eif_pkg::ADDR_CTRL1, 32'h0, rd);
      if (es < 3) check(32'(rd[eif_pkg::LVL_BIT]), 32'(es != 1));
    end
    for (int nc = 0; nc < 4; nc++) begin
      div  = (nc == 0) ? 1 : (2 << nc);
      lfsr = lfsr_next(lfsr);
      scen(eif_pkg::ADDR_CTRL1 + 8'h04, 32'(4 | nc), 3'h2, 8'(2 * div - 1), 32'h0);
      scen(eif_pkg::ADDR_CTRL1 + 8'h04, 32'(4 | nc), 3'h2, 8'(4 * div + 2 + lfsr[2:0]),
           32'h1);
    end
    scen(eif_pkg::ADDR_MODE, 32'h2, 3'h0, 8'h14, 32'h0);
    for (int m = 2; m < 7; m++) begin
      scen(eif_pkg::ADDR_MODE, 32'(m), 3'h2, 8'h42, 32'(m < 4));
    end
    scen(eif_pkg::ADDR_MODE, 32'h1, 3'h0, 8'h02, 32'h1);
    scen(eif_pkg::ADDR_GATE, 32'h0, 3'h0, 8'h1E, 32'h0);
    scen(eif_pkg::ADDR_GATE, 32'h1, 3'h0, 8'h1E, 32'h1);
    master <= 1'b0;
    scen(eif_pkg::ADDR_MODE, 32'h0, 3'h0, 8'h1E, 32'h0);
    // request was latched but held back; drop it before the master comes back
    bus(1'b0, eif_pkg::ADDR_PEND, 32'h0, rd);
    check(rd, 32'h1);
    wr(eif_pkg::ADDR_PEND, 32'h0000_003F);
    master <= 1'b1;
    foreach (cnt[i]) cnt[i] = 0;
    wr(eif_pkg::ADDR_PINDIR, 32'h1);
    repeat (100) @(posedge ref_clk);
    check(32'(cnt[0]), 32'h1);
    scen(eif_pkg::ADDR_CTRL4, 32'hC, 3'h4, 8'h00, 32'h3);
    scen(eif_pkg::ADDR_CTRL4, 32'h4, 3'h4, 8'h1E, 32'h1);
    conclude();
  end
endmodule
